// [cfgl_pkg.sv]
package cfgl_pkg;

  // bus geometry
  localparam int          CFGL_ADDR_W = 8;
  localparam int          CFGL_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0]  CFGL_ADDR_OUT_EN     = 8'h00;
  localparam logic [7:0]  CFGL_ADDR_EVT_STATUS = 8'h04;
  localparam logic [7:0]  CFGL_ADDR_EVT_MASK   = 8'h08;
  localparam logic [7:0]  CFGL_ADDR_STATE      = 8'h0C;

  // event status / mask layout
  localparam int          CFGL_EVT_W           = 2;
  localparam int          CFGL_EVT_LOSS_BIT    = 0;
  localparam int          CFGL_EVT_RESTORE_BIT = 1;
  localparam logic [1:0]  CFGL_EVT_STATUS_RST  = 2'h0;
  localparam logic [1:0]  CFGL_EVT_MASK_RST    = 2'h0;

  // state register layout
  localparam int          CFGL_ST_PRESENT_BIT  = 0;
  localparam int          CFGL_ST_PARKED_BIT   = 1;
  localparam int          CFGL_ST_PIN_BIT      = 2;
  localparam int          CFGL_ST_GATE_LSB     = 8;

  // output enable reset value: every output enabled
  localparam logic [15:0] CFGL_OUT_EN_RST      = 16'hFFFF;

  // output count defaults
  localparam int          CFGL_NUM_OUT         = 8;
  localparam int          CFGL_NUM_PIN         = 8;

  // timing: loss interval in ns, core period in ps, derived cycle counts
  localparam int          CFGL_CLK_PERIOD_PS   = 5000;
  localparam int          CFGL_LOSS_TIME_NS    = 100;
  localparam int          CFGL_LOSS_CYCLES     = (CFGL_LOSS_TIME_NS * 1000) / CFGL_CLK_PERIOD_PS;
  localparam int          CFGL_PRESENT_EDGES   = 4;

  // detector states
  typedef enum logic {
    DET_ABSENT,
    DET_PRESENT
  } cfgl_det_e;

  // apb request from the master
  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [CFGL_ADDR_W-1:0] paddr;
    logic [CFGL_DATA_W-1:0] pwdata;
  } cfgl_apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic [CFGL_DATA_W-1:0] prdata;
    logic                   pready;
    logic                   pslverr;
  } cfgl_apb_rsp_s;

endpackage

// [cfgl_sync.sv]
`timescale 1ns/10ps
module cfgl_sync
  import cfgl_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  // asynchronous level in, synchronised level out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // two stages; the first is read by the second only
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // cfgl_sync

// [cfgl_top.sv]
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module cfgl_top
  import cfgl_pkg::*;
#(
  parameter int NUM_OUT     = CFGL_NUM_OUT,
  parameter int NUM_PIN     = CFGL_NUM_PIN,
  parameter bit BANKED      = 1'b0,
  parameter bit HAS_BUS     = 1'b1,
  parameter int LOSS_CYCLES = CFGL_LOSS_CYCLES,
  parameter int PRES_EDGES  = CFGL_PRESENT_EDGES
)(
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_reset_n,
  // apb slave
  input  wire cfgl_apb_req_s      i_apb,
  output cfgl_apb_rsp_s           o_apb,
  // reference input clock, sampled as a pin
  input  wire logic               i_reference_input_clock,
  // active-low enable pins
  input  wire logic [NUM_PIN-1:0] i_pin_output_gate_n,
  // open-drain absence pin
  input  wire logic               i_clock_absent_n_pin_i,
  output logic                    o_clock_absent_n_pin_o,
  output logic                    o_clock_absent_n_pin_oe,
  // gated clock output pairs
  output logic [NUM_OUT-1:0]      o_clk_p,
  output logic [NUM_OUT-1:0]      o_clk_n,
  // interrupt
  output logic                    o_irq
);

  localparam int GAP_W = $clog2(LOSS_CYCLES + 1);
  localparam int EDG_W = $clog2(PRES_EDGES + 1);
  localparam int PER_PIN = (NUM_OUT + NUM_PIN - 1) / NUM_PIN;

  // output index to controlling pin index
  function automatic int pin_of(input int idx);
    pin_of = BANKED ? (idx / PER_PIN) : (idx % NUM_PIN);
  endfunction

  // synchronised pin levels
  logic                ref_s2;
  logic [NUM_PIN-1:0]  pin_n_s2;
  logic                abs_pin_s2;

  // state
  logic                ref_s3_r;
  cfgl_det_e           det_r;
  cfgl_det_e           det_nxt;
  logic [GAP_W-1:0]    gap_r;
  logic [GAP_W-1:0]    gap_nxt;
  logic [EDG_W-1:0]    edg_r;
  logic [EDG_W-1:0]    edg_nxt;
  logic [NUM_OUT-1:0]  out_en_r;
  logic [NUM_OUT-1:0]  gate_r;
  logic [NUM_OUT-1:0]  gate_nxt;
  logic [CFGL_EVT_W-1:0] evt_r;
  logic [CFGL_EVT_W-1:0] evt_nxt;
  logic [CFGL_EVT_W-1:0] mask_r;
  logic                pready_r;

  // pins cross into the core clock domain
  cfgl_sync #(.W(NUM_PIN + 2)) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    ({i_clock_absent_n_pin_i, i_pin_output_gate_n, i_reference_input_clock}),
    .o_sync     ({abs_pin_s2, pin_n_s2, ref_s2})
  );

  // edge detection on the synchronised reference
  wire logic ref_edge = ref_s2 ^ ref_s3_r;
  wire logic ref_rise = ref_s2 & ~ref_s3_r;
  wire logic ref_fall = ~ref_s2 & ref_s3_r;
  wire logic gap_full = (gap_r == GAP_W'(LOSS_CYCLES - 1)) & ~ref_edge;

  // presence detector: count idle cycles and qualifying rising edges
  always_comb
  begin
    det_nxt = det_r;
    gap_nxt = ref_edge ? '0 : (gap_full ? gap_r : gap_r + GAP_W'(1));
    edg_nxt = edg_r;
    case (det_r)
      DET_ABSENT:
      begin
        if (gap_full)
          edg_nxt = '0;                                          // stale edges do not count
        else if (ref_rise)
        begin
          edg_nxt = edg_r + EDG_W'(1);
          if (edg_r == EDG_W'(PRES_EDGES - 1))
          begin
            det_nxt = DET_PRESENT;
            edg_nxt = '0;
          end
        end
      end
      DET_PRESENT:
      begin
        if (gap_full)
          det_nxt = DET_ABSENT;
      end
      default:
        det_nxt = DET_ABSENT;
    endcase
  end

  wire logic loss_evt    = (det_r == DET_PRESENT) & (det_nxt == DET_ABSENT);
  wire logic restore_evt = (det_r == DET_ABSENT) & (det_nxt == DET_PRESENT);

  // detector registers; reset starts absent so the pin is low
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      det_r    <= DET_ABSENT;
      gap_r    <= '0;
      edg_r    <= '0;
      ref_s3_r <= 1'b0;
    end
    else
    begin
      det_r    <= det_nxt;
      gap_r    <= gap_nxt;
      edg_r    <= edg_nxt;
      ref_s3_r <= ref_s2;
    end
  end

  // open-drain pin: data always low, enable while absent
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_clock_absent_n_pin_o  <= 1'b0;
      o_clock_absent_n_pin_oe <= 1'b1;
    end
    else
    begin
      o_clock_absent_n_pin_o  <= 1'b0;
      o_clock_absent_n_pin_oe <= (det_nxt == DET_ABSENT);
    end
  end

  // parked internal input: both legs forced low while the clock is judged absent,
  // so a stopped reference never leaves the complement leg sitting high
  wire logic ref_parked     = ref_s2 & (det_r == DET_PRESENT);
  wire logic ref_parked_inv = ~ref_s2 & (det_r == DET_PRESENT);

  // per-output request and glitch-free gate
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_gate
      wire logic bus_ok = HAS_BUS ? out_en_r[gi] : 1'b1;
      wire logic pin_ok = ~pin_n_s2[pin_of(gi)];
      wire logic req    = bus_ok & pin_ok;
      // gate moves only on a falling reference edge, when the level is low
      assign gate_nxt[gi] = ref_fall ? req : gate_r[gi];
    end
  endgenerate

  // gate and output pairs; a closed gate holds both legs low
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      gate_r  <= '0;
      o_clk_p <= '0;
      o_clk_n <= '0;
    end
    else
    begin
      gate_r  <= gate_nxt;
      o_clk_p <= gate_r & {NUM_OUT{ref_parked}};
      o_clk_n <= gate_r & {NUM_OUT{ref_parked_inv}};
    end
  end

  // apb decode; one wait state keeps pready and prdata registered
  wire logic acc     = i_apb.psel & i_apb.penable;
  wire logic wr_take = acc & i_apb.pwrite & pready_r;
  wire logic sel_en  = (i_apb.paddr == CFGL_ADDR_OUT_EN) & HAS_BUS;
  wire logic sel_st  = (i_apb.paddr == CFGL_ADDR_EVT_STATUS);
  wire logic sel_msk = (i_apb.paddr == CFGL_ADDR_EVT_MASK);
  wire logic sel_sta = (i_apb.paddr == CFGL_ADDR_STATE);
  wire logic mapped  = sel_en | sel_st | sel_msk | sel_sta;
  wire logic [CFGL_EVT_W-1:0] evt_clr = (wr_take & sel_st) ? i_apb.pwdata[CFGL_EVT_W-1:0] : '0;
  wire logic [CFGL_EVT_W-1:0] evt_set = {restore_evt, loss_evt};

  // sticky events: a set in the clearing cycle wins
  assign evt_nxt = (evt_r & ~evt_clr) | evt_set;

  // read data mux
  logic [CFGL_DATA_W-1:0] rd_data;
  always_comb
  begin
    rd_data = '0;
    if (sel_en)
      rd_data[NUM_OUT-1:0] = out_en_r;
    else if (sel_st)
      rd_data[CFGL_EVT_W-1:0] = evt_r;
    else if (sel_msk)
      rd_data[CFGL_EVT_W-1:0] = mask_r;
    else if (sel_sta)
    begin
      rd_data[CFGL_ST_PRESENT_BIT] = (det_r == DET_PRESENT);
      rd_data[CFGL_ST_PARKED_BIT]  = (det_r == DET_ABSENT);
      rd_data[CFGL_ST_PIN_BIT]     = abs_pin_s2;
      rd_data[CFGL_ST_GATE_LSB +: NUM_OUT] = gate_r;
    end
  end

  // bus handshake and answer
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pready_r <= 1'b0;
      o_apb    <= '0;
    end
    else
    begin
      pready_r       <= acc & ~pready_r;
      o_apb.pready   <= acc & ~pready_r;
      o_apb.pslverr  <= acc & ~pready_r & ~mapped;               // unmapped answers an error
      o_apb.prdata   <= (acc & ~pready_r & ~i_apb.pwrite) ? rd_data : '0;
    end
  end

  // software registers
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      out_en_r <= CFGL_OUT_EN_RST[NUM_OUT-1:0];
      evt_r    <= CFGL_EVT_STATUS_RST;
      mask_r   <= CFGL_EVT_MASK_RST;
      o_irq    <= 1'b0;
    end
    else
    begin
      if (wr_take & sel_en)
        out_en_r <= i_apb.pwdata[NUM_OUT-1:0];
      if (wr_take & sel_msk)
        mask_r <= i_apb.pwdata[CFGL_EVT_W-1:0];
      evt_r <= evt_nxt;
      o_irq <= |(evt_nxt & mask_r);                              // level, follows status
    end
  end

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_idle_full;
    (det_r == DET_PRESENT) && gap_full;
  endsequence

  sequence s_loss_seen;
    ##1 (det_r == DET_ABSENT) && o_clock_absent_n_pin_oe;
  endsequence

  property p_loss_detect;
    s_idle_full |-> s_loss_seen;
  endproperty
  a_loss_detect: assert property (p_loss_detect) else $error("idle interval did not assert absence");

  property p_pin_tracks;
    o_clock_absent_n_pin_oe == (det_r == DET_ABSENT) && !o_clock_absent_n_pin_o;
  endproperty
  a_pin_tracks: assert property (p_pin_tracks) else $error("absence pin disagrees with detector");

  property p_loss_flag;
    loss_evt |=> evt_r[CFGL_EVT_LOSS_BIT];
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("loss event flag not set");

  property p_loss_sticky;
    evt_r[CFGL_EVT_LOSS_BIT] && !(wr_take && sel_st && i_apb.pwdata[CFGL_EVT_LOSS_BIT])
      |=> evt_r[CFGL_EVT_LOSS_BIT];
  endproperty
  a_loss_sticky: assert property (p_loss_sticky) else $error("loss flag dropped without clear");

  property p_parked;
    (det_r == DET_ABSENT) |=> ((o_clk_p | o_clk_n) == '0);
  endproperty
  a_parked: assert property (p_parked) else $error("output toggled while input parked");

  property p_closed_low;
    1'b1 |=> ((o_clk_p | o_clk_n) & ~$past(gate_r)) == '0;
  endproperty
  a_closed_low: assert property (p_closed_low) else $error("closed gate left a leg high");

  property p_gate_on_fall;
    (gate_r != $past(gate_r)) |-> $past(ref_fall) && !$past(ref_s2);
  endproperty
  a_gate_on_fall: assert property (p_gate_on_fall) else $error("gate moved outside clock low");

  property p_gate_hold;
    !ref_fall |=> $stable(gate_r);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate moved without a clock edge");

  property p_pin_stop;
    ref_fall && pin_n_s2[pin_of(0)] |=> !gate_r[0];
  endproperty
  a_pin_stop: assert property (p_pin_stop) else $error("high enable pin did not stop output");

  property p_present_edges;
    (det_r == DET_ABSENT) && (det_nxt == DET_PRESENT) |-> ref_rise && (edg_r == EDG_W'(PRES_EDGES - 1));
  endproperty
  a_present_edges: assert property (p_present_edges) else $error("released before enough edges");

endmodule // cfgl_top

// [cfgl_far_end_model.sv]
`timescale 1ns/10ps
module cfgl_far_end_model
  import cfgl_pkg::*;
(
  // clock
  input  wire logic i_core_clk,
  // far-side controls from the bench
  input  wire logic i_run,
  // open-drain pin as driven by the device
  input  wire logic i_pin_o,
  input  wire logic i_pin_oe,
  // reference clock and resolved pin wire
  output logic      o_ref,
  output logic      o_pin_wire
);
  logic [2:0] cnt_r;

  // reference runs 8 core cycles a period, parks low when stopped
  always_ff @(posedge i_core_clk)
  begin
    cnt_r <= i_run ? cnt_r + 3'h1 : 3'h0;
  end

  assign o_ref = i_run & cnt_r[2];

  // board pull-up: the wire is low only while the device pulls it
  assign o_pin_wire = i_pin_oe ? i_pin_o : 1'b1;
endmodule // cfgl_far_end_model

// [cfgl_top_tb_top.sv]
`timescale 1ns/10ps
module cfgl_top_tb_top
  import cfgl_pkg::*;
;
  localparam int LOSS = 8;
  logic          i_core_clk = 1'b0;
  logic          i_reset_n  = 1'b0;
  cfgl_apb_req_s req        = '0;
  cfgl_apb_rsp_s rsp;
  logic          run        = 1'b0;
  logic [7:0]    gate_n     = 8'h00;
  logic          ref_clk, pin_o, pin_oe, pin_w, irq;
  logic [7:0]    clk_p, clk_n, sp, sn;
  logic [3:0]    clkb_p, clkb_n, sbp, sbn;
  logic          pin_oe_b;
  logic [31:0]   q;
  logic [31:0]   gsave;
  logic          e;
  int            n_errors = 0;
  int            cmp_count = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  cfgl_top #(.LOSS_CYCLES(LOSS), .PRES_EDGES(2)) dut (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_apb(req), .o_apb(rsp),
    .i_reference_input_clock(ref_clk), .i_pin_output_gate_n(gate_n),
    .i_clock_absent_n_pin_i(pin_w), .o_clock_absent_n_pin_o(pin_o),
    .o_clock_absent_n_pin_oe(pin_oe), .o_clk_p(clk_p), .o_clk_n(clk_n), .o_irq(irq));

  // banked variant without a bus: two pins, each gating a pair of outputs
  cfgl_top #(.NUM_OUT(4), .NUM_PIN(2), .BANKED(1'b1), .HAS_BUS(1'b0),
             .LOSS_CYCLES(LOSS), .PRES_EDGES(2)) dut_b (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_apb(req), .o_apb(),
    .i_reference_input_clock(ref_clk), .i_pin_output_gate_n(gate_n[1:0]),
    .i_clock_absent_n_pin_i(~pin_oe_b), .o_clock_absent_n_pin_o(),
    .o_clock_absent_n_pin_oe(pin_oe_b), .o_clk_p(clkb_p), .o_clk_n(clkb_n), .o_irq());

  cfgl_far_end_model far (
    .i_core_clk(i_core_clk), .i_run(run), .i_pin_o(pin_o), .i_pin_oe(pin_oe),
    .o_ref(ref_clk), .o_pin_wire(pin_w));

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_core_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge i_core_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      t++;
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    chk("pready_wait", 32'h2, t);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask

  // settle past the synchronisers, then collect which legs toggled
  task automatic watch(input logic [7:0] xp, input logic [3:0] xb);
    repeat (30) @(posedge i_core_clk);
    sp = 8'h00;
    sn = 8'h00;
    sbp = 4'h0;
    sbn = 4'h0;
    repeat (40)
    begin
      @(posedge i_core_clk);
      sp = sp | clk_p;
      sn = sn | clk_n;
      sbp = sbp | clkb_p;
      sbn = sbn | clkb_n;
    end
    chk("clk_p", {24'h0, xp}, {24'h0, sp});
    chk("clk_n", {24'h0, xp}, {24'h0, sn});
    chk("bank_clk_p", {28'h0, xb}, {28'h0, sbp});
    chk("bank_clk_n", {28'h0, xb}, {28'h0, sbn});
  endtask

  // wait for the absence pin enable to reach a level, bounded
  task automatic wait_oe(input logic v);
    int t;
    for (t = 0; t < 60 && pin_oe !== v; t++)
      @(posedge i_core_clk);
    chk("pin_oe", {31'h0, v}, {31'h0, pin_oe});
  endtask

  initial
  begin
    #200us;
    n_errors++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    chk("pin_oe_rst", 32'h1, {31'h0, pin_oe});
    rd(CFGL_ADDR_OUT_EN, 32'h0000_00FF, "out_en_rst");
    rd(CFGL_ADDR_EVT_STATUS, 32'h0, "status_rst");
    rd(CFGL_ADDR_EVT_MASK, 32'h0, "mask_rst");
    $display("reset test done");

    run <= 1'b1;
    wait_oe(1'b0);
    rd(CFGL_ADDR_STATE, 32'h0000_FF05, "state_run");
    watch(8'hFF, 4'hF);
    rd(CFGL_ADDR_EVT_STATUS, 32'h2, "restore_flag");
    apb(1'b1, CFGL_ADDR_EVT_STATUS, 32'h2);
    $display("start test done");

    apb(1'b1, CFGL_ADDR_OUT_EN, 32'h0000_00FE);
    watch(8'hFE, 4'hF);
    apb(1'b1, CFGL_ADDR_OUT_EN, 32'h0000_00FF);
    watch(8'hFF, 4'hF);
    gate_n <= 8'h02;
    watch(8'hFD, 4'h3);
    gate_n <= 8'h03;
    watch(8'hFC, 4'h0);
    gate_n <= 8'h00;
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    $display("enable test done");

    apb(1'b1, CFGL_ADDR_EVT_MASK, 32'h1);
    run <= 1'b0;
    wait_oe(1'b1);
    chk("pin_wire", 32'h0, {31'h0, pin_w});
    watch(8'h00, 4'h0);
    apb(1'b0, CFGL_ADDR_STATE, 32'h0);
    chk("parked", 32'h2, q & 32'h3);
    gsave = q & 32'hFF00;
    rd(CFGL_ADDR_EVT_STATUS, 32'h1, "loss_flag");
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, CFGL_ADDR_OUT_EN, 32'h0);
    repeat (30) @(posedge i_core_clk);
    apb(1'b0, CFGL_ADDR_STATE, 32'h0);
    chk("gate_frozen", gsave, q & 32'hFF00);
    apb(1'b1, CFGL_ADDR_EVT_STATUS, 32'h0);
    rd(CFGL_ADDR_EVT_STATUS, 32'h1, "sticky");
    apb(1'b1, CFGL_ADDR_EVT_STATUS, 32'h1);
    rd(CFGL_ADDR_EVT_STATUS, 32'h0, "cleared");
    repeat (2) @(posedge i_core_clk);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("loss test done");
    finish_test();
  end
endmodule // cfgl_top_tb_top
